// ### core/fsm_defs.vh
// Constants for the fieldbus slave state logic: offsets, fields, resets
`ifndef FSM_DEFS_VH
`define FSM_DEFS_VH
// Register byte offsets
`define FSM_OFF_CTRL      12'h000
`define FSM_OFF_STATUS    12'h004
`define FSM_OFF_PARAM     12'h008
`define FSM_OFF_CFG       12'h00c
`define FSM_OFF_MAPWR     12'h010
`define FSM_OFF_MAPCNT    12'h014
`define FSM_OFF_ACTIVE    12'h018
// Communication state codes
`define FSM_ST_INIT       4'h1
`define FSM_ST_PREOP      4'h2
`define FSM_ST_SAFEOP     4'h4
`define FSM_ST_OP         4'h8
// Parameter fields and reset values
`define FSM_BUS_SEL_BIT   0
`define FSM_NODE_LSB      8
`define FSM_NODE_W        7
`define FSM_BUS_SEL_RST   1'h1
`define FSM_NODE_RST      7'h01
// Configuration register bits
`define FSM_CFG_ADDR      0
`define FSM_CFG_SM0       1
`define FSM_CFG_SM1       2
`define FSM_CFG_DCINIT    3
`define FSM_CFG_SM2       4
`define FSM_CFG_SM3       5
`define FSM_CFG_FMMU      6
`define FSM_CFG_DCREQ     7
`define FSM_CFG_DCOK      8
`define FSM_CFG_MAPOK     9
// Error codes
`define FSM_ERR_NONE      4'h0
`define FSM_ERR_MBX       4'h1
`define FSM_ERR_PD        4'h2
`define FSM_ERR_DC        4'h3
`define FSM_ERR_TRANS     4'h4
`define FSM_ERR_OUTDATA   4'h5
`endif

// ### core/fsm_axil_slave.v
// AXI4-Lite register port for the fieldbus slave state logic
`timescale 1ns/1ps
module fsm_axil_slave (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Register side
  output reg         wr_stb,
  output reg  [11:0] wr_addr,
  output reg  [31:0] wr_data,
  output reg  [3:0]  wr_strb,
  input  wire        wr_err,
  output wire [11:0] rd_addr,
  input  wire [31:0] rd_data,
  input  wire        rd_err
);
  reg        aw_q;
  reg        w_q;
  reg [11:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0]  ws_q;

  // Each channel is held until taken; response waits for both halves
  assign s_axi_awready = aresetn & ~aw_q & ~s_axi_bvalid & ~wr_stb;
  assign s_axi_wready  = aresetn & ~w_q & ~s_axi_bvalid & ~wr_stb;
  assign s_axi_arready = aresetn & ~s_axi_rvalid;
  assign rd_addr       = s_axi_araddr;

  // Write path: capture address and data in any order, then strobe
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awa_q        <= 12'h000;
      wd_q         <= 32'h0000_0000;
      ws_q         <= 4'h0;
      wr_stb       <= 1'b0;
      wr_addr      <= 12'h000;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      wr_stb <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (aw_q && w_q) begin
        aw_q    <= 1'b0;
        w_q     <= 1'b0;
        wr_stb  <= 1'b1;
        wr_addr <= awa_q;
        wr_data <= wd_q;
        wr_strb <= ws_q;
      end
      if (wr_stb) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path: data registered on the cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_err ? 2'b10 : 2'b00;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### core/fsm_slave_state.v
// Fieldbus slave communication state machine with register access
//
// Function
// - Bus select 0 disables the fieldbus, 1 (default) enables it, applied at restart.
// - Node number takes 0 to 127, defaults to 1, and applies only at restart.
// - The state only changes when the master requests a new state.
// - Init offers neither mailbox nor cyclic process data exchange.
// - Init to Pre-Op completes only if the mailbox channels are set up correctly.
// - Pre-Op serves the mailbox but no cyclic process data.
// - Pre-Op to Safe-Op checks process data channels and, if needed, clock settings.
// - Safe-Op delivers inputs but does not act on outputs.
// - Operational exchanges process data in both directions.
// - Each cycle exchanges the entries selected by the current mapping.
// - Mailbox transfers may read or write any dictionary entry.
// - Channels 0/1 carry mailbox out/in, channels 2/3 process data out/in.
// - Mapping and assignment entries are writable only in Pre-Op.
//
// Register map, one 32-bit word each
//   0x000 control: [3:0] requested state, a write is a request
//   0x004 status: [3:0] state, [7:4] error code, [8] error flag
//   0x008 stored parameters: [0] bus select, [14:8] node number
//   0x00c configuration done by the master, one bit per item
//   0x010 process data mapping, writable in Pre-Op only
//   0x014 counters: [15:0] exchange cycles, [31:16] refused mapping writes
//   0x018 active parameters, same layout as the stored ones
// Configuration bits
//   0 station address, 1 and 2 mailbox channels, 3 clock sync init
//   4 and 5 process data channels, 6 mapping units
//   7 clock settings required, 8 clock settings good, 9 mapping good
// State codes are one-hot: 1 Init, 2 Pre-Op, 4 Safe-Op, 8 Operational
// Moves that may complete
//   Init to Pre-Op, Pre-Op to Safe-Op, Safe-Op to Operational
//   Safe-Op or Operational back to Pre-Op, Operational to Safe-Op
//   any state back to Init, which needs no check
// Error codes in the status word
//   1 station address, mailbox channels or clock sync init not set up
//   2 process data channels, mapping units or mapping not set up
//   3 clock settings required but not good
//   4 illegal code or move, or the same state again other than Init
//   5 no valid output data when Operational is requested
// A successful move clears the error flag and code; a failed one
// leaves the state alone so the master can read why and retry.
// Limitations
//   Stored parameters survive aresetn, which stands for a restart;
//   only power-up brings back their defaults.
//   A cleared bus select holds the state in Init and ignores requests,
//   so a master cannot raise an error flag while the bus is off.
//   The mapping is a single word here; its contents are opaque.
//   Mailbox and process data payloads live outside this block; it
//   only opens and closes the channels and marks each cycle.
//   The cycle strobe follows a tick by one edge while inputs are open.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "fsm_defs.vh"
module fsm_slave_state #(
  parameter MAP_W = 16
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // AXI4-Lite
  input  wire [11:0]      s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output wire [1:0]       s_axi_bresp,
  output wire             s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [11:0]      s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output wire [31:0]      s_axi_rdata,
  output wire [1:0]       s_axi_rresp,
  output wire             s_axi_rvalid,
  input  wire             s_axi_rready,
  // Cyclic exchange and mailbox gating
  input  wire             cycle_tick,
  input  wire             out_data_valid,
  output reg              bus_enabled,
  output reg  [6:0]       node_number,
  output reg              mbx_out_en,
  output reg              mbx_in_en,
  output reg              pd_in_en,
  output reg              pd_out_en,
  output reg              pd_cycle_stb,
  output reg  [MAP_W-1:0] pd_map_sel,
  output reg  [3:0]       comm_state
);
  wire        wr_stb;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [11:0] rd_addr;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg         wr_err;

  reg  [3:0]       state_q;
  reg  [3:0]       req_q;
  reg  [3:0]       err_code_q;
  reg              err_flag_q;
  // Retained store: keeps its value through aresetn, defaults at power-up
  reg              bus_sel_q = `FSM_BUS_SEL_RST;
  reg  [6:0]       node_q    = `FSM_NODE_RST;
  reg  [9:0]       cfg_q;
  reg  [MAP_W-1:0] map_q;
  reg  [15:0]      map_rej_q;
  reg  [15:0]      cycle_cnt_q;
  reg              restart_q;

  // Bus slave
  fsm_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // True when the code is one of the four legal states
  function legal_state;
    input [3:0] s;
    begin
      legal_state = (s == `FSM_ST_INIT) || (s == `FSM_ST_PREOP) ||
                    (s == `FSM_ST_SAFEOP) || (s == `FSM_ST_OP);
    end
  endfunction

  // Error code for a requested move, or none when it may complete
  function [3:0] check_move;
    input [3:0] cur;
    input [3:0] req;
    input [9:0] cfg;
    input       outv;
    begin
      check_move = `FSM_ERR_NONE;
      if (req == `FSM_ST_INIT) begin
        check_move = `FSM_ERR_NONE;
      end else if (cur == `FSM_ST_INIT && req == `FSM_ST_PREOP) begin
        if (!(cfg[`FSM_CFG_ADDR] && cfg[`FSM_CFG_SM0] &&
              cfg[`FSM_CFG_SM1] && cfg[`FSM_CFG_DCINIT]))
          check_move = `FSM_ERR_MBX;
      end else if (cur == `FSM_ST_PREOP && req == `FSM_ST_SAFEOP) begin
        if (!(cfg[`FSM_CFG_SM2] && cfg[`FSM_CFG_SM3] &&
              cfg[`FSM_CFG_FMMU] && cfg[`FSM_CFG_MAPOK]))
          check_move = `FSM_ERR_PD;
        else if (cfg[`FSM_CFG_DCREQ] && !cfg[`FSM_CFG_DCOK])
          check_move = `FSM_ERR_DC;
      end else if (cur == `FSM_ST_SAFEOP && req == `FSM_ST_OP) begin
        if (!outv)
          check_move = `FSM_ERR_OUTDATA;
      end else if (cur == `FSM_ST_SAFEOP && req == `FSM_ST_PREOP) begin
        check_move = `FSM_ERR_NONE;
      end else if (cur == `FSM_ST_OP &&
                   (req == `FSM_ST_SAFEOP || req == `FSM_ST_PREOP)) begin
        check_move = `FSM_ERR_NONE;
      end else begin
        check_move = `FSM_ERR_TRANS;
      end
    end
  endfunction

  // Byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  stb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (stb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  wire [31:0] param_w = merge({16'h0000, 1'b0, node_q, 7'h00, bus_sel_q},
                              wr_data, wr_strb);
  wire [31:0] cfg_w   = merge({22'h000000, cfg_q}, wr_data, wr_strb);
  wire [31:0] map_w   = merge({{(32-MAP_W){1'b0}}, map_q}, wr_data, wr_strb);
  wire        wr_ctrl = wr_stb && wr_addr == `FSM_OFF_CTRL;
  wire        wr_map  = wr_stb && wr_addr == `FSM_OFF_MAPWR;
  wire        map_ok  = state_q == `FSM_ST_PREOP;

  // Write decode errors: unmapped offsets, read-only registers and mapping writes outside Pre-Op
  always @* begin
    wr_err = 1'b0;
    case (wr_addr)
      `FSM_OFF_CTRL, `FSM_OFF_PARAM, `FSM_OFF_CFG: wr_err = 1'b0;
      `FSM_OFF_MAPWR: wr_err = !map_ok;
      default: wr_err = 1'b1;
    endcase
  end

  // Stored parameters and configuration; parameters wait for restart
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q     <= 10'h000;
      map_q     <= {MAP_W{1'b0}};
      map_rej_q <= 16'h0000;
      req_q     <= `FSM_ST_INIT;
    end else if (wr_stb) begin
      case (wr_addr)
        `FSM_OFF_PARAM: begin
          bus_sel_q <= param_w[`FSM_BUS_SEL_BIT];
          node_q    <= param_w[`FSM_NODE_LSB +: `FSM_NODE_W];
        end
        `FSM_OFF_CFG: cfg_q <= cfg_w[9:0];
        `FSM_OFF_MAPWR: begin
          if (map_ok)
            map_q <= map_w[MAP_W-1:0];
          else
            map_rej_q <= map_rej_q + 16'h0001;
        end
        `FSM_OFF_CTRL: req_q <= wr_data[3:0];
        default: req_q <= req_q;
      endcase
    end
  end

  // Restart latch: stored parameters become active at reset release only
  always @(posedge aclk) begin
    if (!aresetn) begin
      restart_q   <= 1'b1;
      bus_enabled <= `FSM_BUS_SEL_RST;
      node_number <= `FSM_NODE_RST;
    end else begin
      restart_q <= 1'b0;
      if (restart_q) begin
        bus_enabled <= bus_sel_q;
        node_number <= node_q;
      end
    end
  end

  // Communication states move only on a master request
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= `FSM_ST_INIT;
      err_flag_q <= 1'b0;
      err_code_q <= `FSM_ERR_NONE;
    end else if (!bus_enabled) begin
      state_q <= `FSM_ST_INIT; // Fieldbus off: stay idle
    end else if (wr_ctrl) begin
      if (!legal_state(wr_data[3:0]) ||
          check_move(state_q, wr_data[3:0], cfg_q, out_data_valid)
            != `FSM_ERR_NONE) begin
        err_flag_q <= 1'b1;
        err_code_q <= legal_state(wr_data[3:0]) ?
                      check_move(state_q, wr_data[3:0], cfg_q,
                                 out_data_valid) : `FSM_ERR_TRANS;
      end else begin
        state_q    <= wr_data[3:0];
        err_flag_q <= 1'b0;
        err_code_q <= `FSM_ERR_NONE;
      end
    end
  end

  // Service gating per state; channel roles are fixed per number
  always @(posedge aclk) begin
    if (!aresetn) begin
      mbx_out_en <= 1'b0;
      mbx_in_en  <= 1'b0;
      pd_in_en   <= 1'b0;
      pd_out_en  <= 1'b0;
      comm_state <= `FSM_ST_INIT;
    end else begin
      comm_state <= state_q;
      mbx_out_en <= state_q != `FSM_ST_INIT;
      mbx_in_en  <= state_q != `FSM_ST_INIT;
      pd_in_en   <= state_q == `FSM_ST_SAFEOP ||
                    state_q == `FSM_ST_OP;
      pd_out_en  <= state_q == `FSM_ST_OP;
    end
  end

  // Cyclic exchange strobe carries the current mapping selection
  always @(posedge aclk) begin
    if (!aresetn) begin
      pd_cycle_stb <= 1'b0;
      pd_map_sel   <= {MAP_W{1'b0}};
      cycle_cnt_q  <= 16'h0000;
    end else begin
      pd_cycle_stb <= cycle_tick && pd_in_en;
      if (cycle_tick && pd_in_en) begin
        pd_map_sel  <= map_q;
        cycle_cnt_q <= cycle_cnt_q + 16'h0001;
      end
    end
  end

  // Read mux; unmapped offsets answer SLVERR with zero data
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (rd_addr)
      `FSM_OFF_CTRL:   rd_data = {28'h0000000, req_q};
      `FSM_OFF_STATUS: rd_data = {23'h000000, err_flag_q, err_code_q,
                                  state_q};
      `FSM_OFF_PARAM:  rd_data = {16'h0000, 1'b0, node_q, 7'h00, bus_sel_q};
      `FSM_OFF_CFG:    rd_data = {22'h000000, cfg_q};
      `FSM_OFF_MAPWR:  rd_data = {{(32-MAP_W){1'b0}}, map_q};
      `FSM_OFF_MAPCNT: rd_data = {map_rej_q, cycle_cnt_q};
      `FSM_OFF_ACTIVE: rd_data = {16'h0000, 1'b0, node_number, 7'h00,
                                  bus_enabled};
      default:         rd_err  = 1'b1;
    endcase
  end
endmodule

// ### dv/fsm_slave_state_asserts.sv
// Port checker of the fieldbus slave state logic
`timescale 1ns/1ps
`include "fsm_defs.vh"
module fsm_chk #(
  parameter MAP_W = 16
) (
  // Clock and reset
  input wire             aclk,
  input wire             aresetn,
  // Bus answers
  input wire             s_axi_bvalid,
  input wire             s_axi_arvalid,
  input wire             s_axi_arready,
  input wire             s_axi_rvalid,
  // Gating and cycle
  input wire             cycle_tick,
  input wire             bus_enabled,
  input wire [6:0]       node_number,
  input wire             mbx_out_en,
  input wire             mbx_in_en,
  input wire             pd_in_en,
  input wire             pd_out_en,
  input wire             pd_cycle_stb,
  input wire [MAP_W-1:0] pd_map_sel,
  input wire [3:0]       comm_state
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Exchanges open in state order; enables lag the state by one edge
  chk_out_gate: assert property (pd_out_en |-> pd_in_en)
    else $error("outputs enabled without inputs");
  chk_in_gate: assert property (pd_in_en |-> mbx_out_en)
    else $error("inputs enabled without mailbox");
  chk_mbx_pair: assert property (mbx_out_en == mbx_in_en)
    else $error("mailbox channels differ");
  chk_init_idle: assert property (comm_state == `FSM_ST_INIT &&
    $past(comm_state) == `FSM_ST_INIT |-> !mbx_out_en && !pd_in_en)
    else $error("exchange open in init");
  // Cycle strobe follows the tick by one edge, snapshot only then
  chk_cycle_stb: assert property (cycle_tick && pd_in_en |=> pd_cycle_stb)
    else $error("cycle strobe missing");
  chk_stb_cause: assert property (pd_cycle_stb |-> $past(cycle_tick))
    else $error("cycle strobe without tick");
  chk_map_hold: assert property (!pd_cycle_stb |-> $stable(pd_map_sel))
    else $error("mapping moved between cycles");
  // Parameters only take effect at restart
  chk_param_hold: assert property ($past(aresetn) && $past(aresetn, 2)
    |-> $stable(node_number) && $stable(bus_enabled))
    else $error("active parameters changed in run");
  // The state word moves one edge after bvalid rises for the request
  chk_state_cause: assert property ($changed(comm_state)
    |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("state moved without a request");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind fsm_slave_state fsm_chk #(.MAP_W(MAP_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .cycle_tick(cycle_tick),
  .bus_enabled(bus_enabled), .node_number(node_number),
  .mbx_out_en(mbx_out_en), .mbx_in_en(mbx_in_en), .pd_in_en(pd_in_en),
  .pd_out_en(pd_out_en), .pd_cycle_stb(pd_cycle_stb),
  .pd_map_sel(pd_map_sel), .comm_state(comm_state)
);

// ### dv/fsm_master_model.sv
// Cyclic side of the fieldbus master controller
`timescale 1ns/1ps
module fsm_master_model (
  // Clock and reset
  input wire  aclk,
  input wire  aresetn,
  // Control from the bench
  input wire  send_out,
  // Towards the slave
  output reg  cycle_tick,
  output reg  out_data_valid
);
  reg [2:0] cnt_q;
  // One cycle every eight clocks; outputs flagged only when sent
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 3'h0;
      cycle_tick <= 1'b0;
      out_data_valid <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      cycle_tick <= (cnt_q == 3'h7);
      out_data_valid <= send_out;
    end
  end
endmodule

// ### dv/fsm_testbench.sv
// Self-checking bench of the fieldbus slave state logic
`timescale 1ns/1ps
`include "fsm_defs.vh"
module testbench;
  logic        aclk = 0, aresetn = 0, send_out = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, seed = 32'h5278c5e1, map_v = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [6:0]  node_v = 0;
  wire         awready, wready, bvalid, arready, rvalid, tick, odv;
  wire         bus_en, mbx_o, mbx_i, pd_in, pd_out, stb;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [6:0]   node;
  wire [15:0]  map_sel;
  wire [3:0]   comm;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  int          bad_count = 0, samples_checked = 0, cyc = 0;
  fsm_slave_state #(.MAP_W(16)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cycle_tick(tick), .out_data_valid(odv),
    .bus_enabled(bus_en), .node_number(node), .mbx_out_en(mbx_o),
    .mbx_in_en(mbx_i), .pd_in_en(pd_in), .pd_out_en(pd_out),
    .pd_cycle_stb(stb), .pd_map_sel(map_sel), .comm_state(comm));
  fsm_master_model u_mst (.aclk(aclk), .aresetn(aresetn),
    .send_out(send_out), .cycle_tick(tick), .out_data_valid(odv));
  always #25 aclk = ~aclk;
  function automatic [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp_port(input string n, input [31:0] e, input [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_rd(input [65:0] n);
    cmp_port("rdata", n[33:2] & n[65:34], rdata & n[65:34]);
    cmp_port("rresp", {30'h0, n[1:0]}, {30'h0, rresp});
  endtask
  task automatic cmp_b(input [1:0] e);
    cmp_port("bresp", {30'h0, e}, {30'h0, bresp});
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input [11:0] a, input [31:0] d, input [1:0] r);
    logic aw, w;
    aw = 1;
    w = 1;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input [11:0] a, input [31:0] e, input [31:0] m,
                    input [1:0] r);
    rq.push_back({m, e, r});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    @(posedge aclk);
  endtask
  // Oldest note meets each answer; a cycle ceiling cuts hangs short
  always @(posedge aclk) begin
    if (rvalid && rready) cmp_rd(rq.pop_front());
    if (bvalid && bready) cmp_b(bq.pop_front());
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  // State walk: each forward step refused first, then retried until it completes, then back to Init
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`FSM_OFF_STATUS, 32'h001, 32'h1ff, 2'b00);
    rd(`FSM_OFF_PARAM, 32'h101, 32'h7f01, 2'b00);
    cmp_port("mbx", 0, mbx_o);
    seed = lfsr(seed);
    node_v = seed[6:0];
    wr(`FSM_OFF_PARAM, {17'h0, node_v, 8'h01}, 2'b00);
    rd(`FSM_OFF_PARAM, {17'h0, node_v, 8'h01}, 32'h7f01, 2'b00);
    rd(`FSM_OFF_ACTIVE, 32'h101, 32'h7f01, 2'b00);
    cmp_port("node", 1, node);
    wr(`FSM_OFF_MAPWR, seed, 2'b10);
    wr(`FSM_OFF_CTRL, `FSM_ST_PREOP, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h111, 32'h1ff, 2'b00);
    wr(`FSM_OFF_CFG, 32'h00f, 2'b00);
    wr(`FSM_OFF_CTRL, `FSM_ST_PREOP, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h002, 32'h0ff, 2'b00);
    cmp_port("mbx", 1, mbx_i);
    cmp_port("pd_in", 0, pd_in);
    seed = lfsr(seed);
    map_v = seed;
    wr(`FSM_OFF_MAPWR, map_v, 2'b00);
    wr(`FSM_OFF_CTRL, `FSM_ST_SAFEOP, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h122, 32'h1ff, 2'b00);
    wr(`FSM_OFF_CFG, 32'h2ff, 2'b00);
    wr(`FSM_OFF_CTRL, `FSM_ST_SAFEOP, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h132, 32'h1ff, 2'b00);
    wr(`FSM_OFF_CFG, 32'h3ff, 2'b00);
    wr(`FSM_OFF_CTRL, `FSM_ST_SAFEOP, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h004, 32'h0ff, 2'b00);
    cmp_port("pd_in", 1, pd_in);
    cmp_port("pd_out", 0, pd_out);
    do @(posedge aclk); while (stb !== 1'b1);
    cmp_port("map", {16'h0, map_v[15:0]}, {16'h0, map_sel});
    wr(`FSM_OFF_CTRL, `FSM_ST_OP, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h154, 32'h1ff, 2'b00);
    send_out <= 1;
    wr(`FSM_OFF_CTRL, `FSM_ST_OP, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h008, 32'h0ff, 2'b00);
    cmp_port("pd_out", 1, pd_out);
    wr(`FSM_OFF_MAPWR, map_v, 2'b10);
    wr(`FSM_OFF_CTRL, 32'h3, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h148, 32'h1ff, 2'b00);
    wr(`FSM_OFF_STATUS, 32'h0, 2'b10);
    rd(12'h020, 32'h0, 32'hffffffff, 2'b10);
    wr(`FSM_OFF_CTRL, `FSM_ST_INIT, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h001, 32'h0ff, 2'b00);
    cmp_port("mbx", 0, mbx_o);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`FSM_OFF_PARAM, {17'h0, node_v, 8'h01}, 32'h7f01, 2'b00);
    rd(`FSM_OFF_ACTIVE, {17'h0, node_v, 8'h01}, 32'h7f01, 2'b00);
    cmp_port("node", {25'h0, node_v}, node);
    rd(`FSM_OFF_STATUS, 32'h001, 32'h1ff, 2'b00);
    // Bus switched off: takes hold only at the next restart
    wr(`FSM_OFF_PARAM, {17'h0, node_v, 8'h00}, 2'b00);
    cmp_port("bus_en", 1, bus_en);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`FSM_OFF_STATUS, 32'h001, 32'h1ff, 2'b00);
    rd(`FSM_OFF_ACTIVE, {17'h0, node_v, 8'h00}, 32'h7f01, 2'b00);
    cmp_port("bus_en", 0, bus_en);
    wr(`FSM_OFF_CFG, 32'h00f, 2'b00);
    wr(`FSM_OFF_CTRL, `FSM_ST_PREOP, 2'b00);
    rd(`FSM_OFF_STATUS, 32'h001, 32'h1ff, 2'b00);
    cmp_port("mbx", 0, mbx_o);
    close_out();
  end
endmodule
